// ==== core/serial_port_pkg.sv ====
package serial_port_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned DIV_W = 16;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned STOP_BIT_IDX = DATA_BITS + 1;
	localparam int unsigned GAP_TIMEOUT_MS = 32;
	localparam int unsigned GAP_TIMEOUT_CYC = CLK_HZ / 1000 * GAP_TIMEOUT_MS;
	localparam int unsigned RESET_DELAY_MS = 35;
	localparam int unsigned RESET_DELAY_CYC = CLK_HZ / 1000 * RESET_DELAY_MS;
	localparam logic [7:0] SYNC_BYTE_1 = 8'h57;
	localparam logic [7:0] SYNC_BYTE_2 = 8'hAB;
	// Baud rate per strap code {high, mid, low}
	localparam int unsigned BAUD_RATE_TABLE [0:7] = '{921600, 2000000, 1000000, 250000,
		460800, 115200, 57600, 9600};
	// Host register map, byte addresses
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_MASK = 8'h10;
	localparam logic [7:0] REG_CFG = 8'h14;
	localparam int unsigned ST_RX = 0;
	localparam int unsigned ST_TXDONE = 1;
	localparam int unsigned ST_FERR = 2;
	localparam int unsigned ST_RESET = 3;
	localparam int unsigned CFG_EXT_RESET = 3;
	localparam logic [7:0] CFG_RESET = 8'h77;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [1:0] SEQ_LEN = 2'h3;

	typedef enum logic [1:0]
	{
		PKT_SYNC1 = 2'b00,
		PKT_SYNC2 = 2'b01,
		PKT_CMD = 2'b11,
		PKT_DATA = 2'b10
	} pkt_state_t;

	function automatic logic [DIV_W-1:0] baud_divisor(input logic [2:0] code);
		int unsigned rate;
		rate = BAUD_RATE_TABLE[code];
		return DIV_W'((CLK_HZ + rate / 2) / rate);
	endfunction
endpackage

// ==== core/serial_link_if.sv ====
interface serial_link_if;
	logic host_to_dev;
	logic dev_to_host;
	logic baud_strap_low;
	logic baud_strap_mid;
	logic baud_strap_high;
	logic external_reset_in;
	logic reset_status;

	modport device
	(
		input host_to_dev,
		input baud_strap_low,
		input baud_strap_mid,
		input baud_strap_high,
		input external_reset_in,
		output dev_to_host,
		output reset_status
	);
	modport host
	(
		output host_to_dev,
		output baud_strap_low,
		output baud_strap_mid,
		output baud_strap_high,
		output external_reset_in,
		input dev_to_host,
		input reset_status
	);
endinterface

// ==== core/command_port_device.sv ====
// Contract
// - Frame: start, eight data, stop, no parity.
// - Strap pins pick baud after every reset.
// - Strap code maps to eight fixed rates.
// - Baud change command accepted at any time; ignored here during the reset delay.
// - Host sends 57h then ABh first.
// - Sync or command gap over 32ms discards.
// - Byte after sync is command; data follows.
// - Output bytes sent in order, one each.
// - Interrupt status byte sent unprompted on completion.
// - After completion host restarts with sync byte.
// - High external reset resets device asynchronously.
// - Reset held about 35ms after release.
// - Reset status high until interface initialised.

// ==========================================
// Byte serialiser and deserialiser
module serial_byte_engine
	import serial_port_pkg::*;
(
	input wire logic sys_clk_i, // Core clock
	input wire logic rst_n_i, // Async reset, low
	input wire logic [DIV_W-1:0] div_i, // Cycles per bit
	input wire logic rx_i, // Serial in
	output logic tx_o, // Serial out
	input wire logic [7:0] tx_data_i, // Byte to send
	input wire logic tx_valid_i, // Byte offered
	output logic tx_ready_o, // Transmitter idle
	output logic [7:0] rx_data_o, // Received byte
	output logic rx_valid_o, // Byte received pulse
	output logic rx_err_o // Bad stop bit pulse
);
	logic tx_busy_r;
	logic [DIV_W-1:0] tx_cnt_r;
	logic [3:0] tx_bit_r;
	logic [STOP_BIT_IDX:0] tx_shift_r;
	logic rx_busy_r;
	logic rx_prev_r;
	logic [DIV_W-1:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [7:0] rx_shift_r;

	assign tx_o = tx_shift_r[0];
	assign tx_ready_o = !tx_busy_r;

	// ==========================================
	// Transmit
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_busy_r <= 1'b0;
			tx_cnt_r <= '0;
			tx_bit_r <= 4'h0;
			tx_shift_r <= '1;
		end
		else if (!tx_busy_r)
		begin
			if (tx_valid_i)
			begin
				tx_shift_r <= {1'b1, tx_data_i, 1'b0};
				tx_busy_r <= 1'b1;
				tx_cnt_r <= div_i - 1'b1;
				tx_bit_r <= 4'h0;
			end
		end
		else if (tx_cnt_r == '0)
		begin
			tx_cnt_r <= div_i - 1'b1;
			tx_shift_r <= {1'b1, tx_shift_r[STOP_BIT_IDX:1]};
			if (tx_bit_r == 4'(STOP_BIT_IDX))
				tx_busy_r <= 1'b0;
			else
				tx_bit_r <= tx_bit_r + 4'h1;
		end
		else
			tx_cnt_r <= tx_cnt_r - 1'b1;
	end

	// ==========================================
	// Receive
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_busy_r <= 1'b0;
			rx_prev_r <= 1'b1;
			rx_cnt_r <= '0;
			rx_bit_r <= 4'h0;
			rx_shift_r <= 8'h00;
			rx_data_o <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_err_o <= 1'b0;
		end
		else
		begin
			rx_prev_r <= rx_i;
			rx_valid_o <= 1'b0;
			rx_err_o <= 1'b0;
			if (!rx_busy_r)
			begin
				if (rx_prev_r && !rx_i)
				begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= div_i >> 1;
					rx_bit_r <= 4'h0;
				end
			end
			else if (rx_cnt_r == '0)
			begin
				rx_cnt_r <= div_i - 1'b1;
				if (rx_bit_r == 4'h0)
				begin
					// Glitch, not a start bit
					if (rx_i)
						rx_busy_r <= 1'b0;
					else
						rx_bit_r <= 4'h1;
				end
				else if (rx_bit_r != 4'(STOP_BIT_IDX))
				begin
					rx_shift_r <= {rx_i, rx_shift_r[7:1]};
					rx_bit_r <= rx_bit_r + 4'h1;
				end
				else
				begin
					rx_busy_r <= 1'b0;
					if (rx_i)
					begin
						rx_data_o <= rx_shift_r;
						rx_valid_o <= 1'b1;
					end
					else
						rx_err_o <= 1'b1;
				end
			end
			else
				rx_cnt_r <= rx_cnt_r - 1'b1;
		end
	end
endmodule

// ==========================================
// Device end of the serial command port
module command_port_device
	import serial_port_pkg::*;
#(
	parameter int unsigned GAP_CYC = GAP_TIMEOUT_CYC,
	parameter int unsigned RST_DELAY_CYC = RESET_DELAY_CYC
)
(
	input wire logic sys_clk_i, // Core clock
	input wire logic rst_n_i, // Power-on reset, low
	serial_link_if.device link, // Serial pins
	output logic port_ready_o, // Out of reset
	output logic cmd_valid_o, // Command code pulse
	output logic [7:0] cmd_code_o, // Command code
	output logic in_valid_o, // Input data pulse
	output logic [7:0] in_data_o, // Input data byte
	input wire logic cmd_done_i, // Command complete
	input wire logic out_valid_i, // Output byte offered
	input wire logic [7:0] out_data_i, // Output byte
	output logic out_ready_o, // Output byte taken
	input wire logic int_valid_i, // Interrupt code offered
	input wire logic [7:0] int_code_i, // Interrupt status code
	output logic int_ready_o, // Interrupt code taken
	input wire logic baud_set_i, // Baud change command
	input wire logic [2:0] baud_code_i, // New baud code
	output logic frame_err_o // Rejected frame pulse
);
	localparam int GAP_W = $clog2(GAP_CYC + 1);
	localparam int DLY_W = $clog2(RST_DELAY_CYC + 1);
	localparam logic [DIV_W-1:0] DIV_RESET = baud_divisor(3'h7);

	if (GAP_CYC < 1 || RST_DELAY_CYC < 1)
	begin : g_bad_param
		$error("Timeout and reset delay need at least one cycle");
	end

	logic core_rst_n;
	logic in_reset_r;
	logic reset_status_r;
	logic [DLY_W-1:0] dly_r;
	logic [DIV_W-1:0] div_r;
	pkt_state_t pkt_state_r;
	logic [GAP_W-1:0] gap_r;
	logic tx_ready;
	logic tx_valid;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_err;

	assign core_rst_n = rst_n_i && !link.external_reset_in;
	assign link.reset_status = reset_status_r;
	assign port_ready_o = !reset_status_r;
	assign frame_err_o = rx_err;

	// ==========================================
	// Reset delay, straps and bit rate
	always_ff @(posedge sys_clk_i or negedge core_rst_n)
	begin
		if (!core_rst_n)
		begin
			in_reset_r <= 1'b1;
			reset_status_r <= 1'b1;
			dly_r <= '0;
			div_r <= DIV_RESET;
		end
		else if (in_reset_r)
		begin
			if (dly_r == DLY_W'(RST_DELAY_CYC - 1))
			begin
				in_reset_r <= 1'b0;
				div_r <= baud_divisor({link.baud_strap_high, link.baud_strap_mid,
					link.baud_strap_low});
			end
			else
				dly_r <= dly_r + 1'b1;
		end
		else
		begin
			reset_status_r <= 1'b0;
			if (baud_set_i)
				div_r <= baud_divisor(baud_code_i);
		end
	end

	// ==========================================
	// Packet framing
	always_ff @(posedge sys_clk_i or negedge core_rst_n)
	begin
		if (!core_rst_n)
		begin
			pkt_state_r <= PKT_SYNC1;
			gap_r <= '0;
			cmd_valid_o <= 1'b0;
			cmd_code_o <= 8'h00;
			in_valid_o <= 1'b0;
			in_data_o <= 8'h00;
		end
		else
		begin
			cmd_valid_o <= 1'b0;
			in_valid_o <= 1'b0;
			if (reset_status_r || rx_err)
				pkt_state_r <= PKT_SYNC1;
			else if (rx_valid)
			begin
				gap_r <= '0;
				unique case (pkt_state_r)
					PKT_SYNC1:
						if (rx_data == SYNC_BYTE_1)
							pkt_state_r <= PKT_SYNC2;
					PKT_SYNC2:
						if (rx_data == SYNC_BYTE_2)
							pkt_state_r <= PKT_CMD;
						else if (rx_data != SYNC_BYTE_1)
							pkt_state_r <= PKT_SYNC1;
					PKT_CMD:
					begin
						cmd_code_o <= rx_data;
						cmd_valid_o <= 1'b1;
						pkt_state_r <= PKT_DATA;
					end
					PKT_DATA:
					begin
						in_data_o <= rx_data;
						in_valid_o <= 1'b1;
					end
				endcase
			end
			else if (pkt_state_r == PKT_DATA)
			begin
				if (cmd_done_i)
					pkt_state_r <= PKT_SYNC1;
			end
			else if (pkt_state_r != PKT_SYNC1)
			begin
				if (gap_r == GAP_W'(GAP_CYC - 1))
				begin
					pkt_state_r <= PKT_SYNC1;
					gap_r <= '0;
				end
				else
					gap_r <= gap_r + 1'b1;
			end
		end
	end

	// ==========================================
	// Output bytes first, then interrupt status
	assign tx_valid = !reset_status_r && (out_valid_i || int_valid_i);
	assign out_ready_o = !reset_status_r && tx_ready;
	assign int_ready_o = !reset_status_r && tx_ready && !out_valid_i;

	serial_byte_engine u_engine
	(
		.sys_clk_i (sys_clk_i),
		.rst_n_i (core_rst_n),
		.div_i (div_r),
		.rx_i (link.host_to_dev),
		.tx_o (link.dev_to_host),
		.tx_data_i (out_valid_i ? out_data_i : int_code_i),
		.tx_valid_i (tx_valid),
		.tx_ready_o (tx_ready),
		.rx_data_o (rx_data),
		.rx_valid_o (rx_valid),
		.rx_err_o (rx_err)
	);
endmodule

// ==== core/command_port_host.sv ====
// ==========================================
// Host end: Wishbone registers to serial commands
module command_port_host
	import serial_port_pkg::*;
(
	input wire logic sys_clk_i, // Core clock
	input wire logic rst_n_i, // Async reset, low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic irq_o, // Interrupt, high
	serial_link_if.host link // Serial pins
);
	logic [7:0] cfg_r;
	logic [2:0] mask_r;
	logic [2:0] status_r;
	logic [7:0] rx_data_r;
	logic [7:0] seq_cmd_r;
	logic [1:0] seq_cnt_r;
	logic [7:0] tx_byte_r;
	logic tx_pend_r;
	logic req;
	logic tx_write;
	logic stall;
	logic acc;
	logic tx_ready;
	logic tx_valid;
	logic tx_fire;
	logic [7:0] tx_data;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_err;
	logic [2:0] status_set;
	logic [2:0] status_clr;

	assign link.baud_strap_low = cfg_r[0];
	assign link.baud_strap_mid = cfg_r[1];
	assign link.baud_strap_high = cfg_r[2];
	assign link.external_reset_in = cfg_r[CFG_EXT_RESET];

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign tx_write = wb_we_i && (wb_adr_i == REG_CMD || wb_adr_i == REG_TXDATA);
	// Hold the ack until the byte path is free
	assign stall = tx_write && (tx_pend_r || seq_cnt_r != 2'h0);
	assign acc = req && !stall;

	// ==========================================
	// Sync bytes, command, data bytes
	always_comb
	begin
		tx_valid = tx_pend_r || seq_cnt_r != 2'h0;
		if (tx_pend_r)
			tx_data = tx_byte_r;
		else if (seq_cnt_r == SEQ_LEN)
			tx_data = SYNC_BYTE_1;
		else if (seq_cnt_r == SEQ_LEN - 2'h1)
			tx_data = SYNC_BYTE_2;
		else
			tx_data = seq_cmd_r;
	end
	assign tx_fire = tx_valid && tx_ready;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			seq_cnt_r <= 2'h0;
			seq_cmd_r <= 8'h00;
			tx_pend_r <= 1'b0;
			tx_byte_r <= 8'h00;
		end
		else if (acc && tx_write && wb_sel_i[0])
		begin
			if (wb_adr_i == REG_CMD)
			begin
				seq_cmd_r <= wb_dat_i[7:0];
				seq_cnt_r <= SEQ_LEN;
			end
			else
			begin
				tx_byte_r <= wb_dat_i[7:0];
				tx_pend_r <= 1'b1;
			end
		end
		else if (tx_fire)
		begin
			if (tx_pend_r)
				tx_pend_r <= 1'b0;
			else
				seq_cnt_r <= seq_cnt_r - 2'h1;
		end
	end

	// ==========================================
	// Registers and bus answer
	assign status_set[ST_RX] = rx_valid;
	assign status_set[ST_TXDONE] = tx_fire && (tx_pend_r || seq_cnt_r == 2'h1);
	assign status_set[ST_FERR] = rx_err;
	assign status_clr = (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_STATUS) ?
		wb_dat_i[2:0] : 3'h0;
	assign irq_o = |(status_r & mask_r);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			status_r <= 3'h0;
			rx_data_r <= 8'h00;
		end
		else
		begin
			// Set wins over clear
			status_r <= (status_r & ~status_clr) | status_set;
			if (rx_valid)
				rx_data_r <= rx_data;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_r <= CFG_RESET;
			mask_r <= MASK_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= acc;
			if (acc && wb_we_i && wb_sel_i[0])
			begin
				if (wb_adr_i == REG_MASK)
					mask_r <= wb_dat_i[2:0];
				if (wb_adr_i == REG_CFG)
					cfg_r <= wb_dat_i[7:0];
			end
			if (acc && !wb_we_i)
			begin
				unique case (wb_adr_i)
					REG_CMD: wb_dat_o <= {24'h0, seq_cmd_r};
					REG_TXDATA: wb_dat_o <= {24'h0, tx_byte_r};
					REG_RXDATA: wb_dat_o <= {24'h0, rx_data_r};
					REG_STATUS: wb_dat_o <= {28'h0, link.reset_status, status_r};
					REG_MASK: wb_dat_o <= {29'h0, mask_r};
					REG_CFG: wb_dat_o <= {24'h0, cfg_r};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	serial_byte_engine u_engine
	(
		.sys_clk_i (sys_clk_i),
		.rst_n_i (rst_n_i),
		.div_i (baud_divisor(cfg_r[6:4])),
		.rx_i (link.dev_to_host),
		.tx_o (link.host_to_dev),
		.tx_data_i (tx_data),
		.tx_valid_i (tx_valid),
		.tx_ready_o (tx_ready),
		.rx_data_o (rx_data),
		.rx_valid_o (rx_valid),
		.rx_err_o (rx_err)
	);
endmodule

// ==== bench/serial_link_props.sv ====
// ==========
// Link checks
module serial_link_props
#(
	parameter int RST_DELAY_CYC = 20,
	parameter int BIT = 10
)
(
	input wire logic sys_clk_i, // Clock
	input wire logic rst_n_i, // Reset, low
	input wire logic host_to_dev, // Host line
	input wire logic dev_to_host, // Device line
	input wire logic external_reset_in, // Device reset
	input wire logic reset_status // Reset status
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RST_LO = RST_DELAY_CYC;
	localparam int RST_HI = RST_DELAY_CYC + 8;
	localparam int START_AT = BIT / 2 - 1;
	localparam int STOP_AT = BIT * 19 / 2 - 1;
	logic [1:0] ln;
	logic [1:0] prev_r;
	logic [1:0] busy_r;
	int cnt_r [2];
	assign ln = {dev_to_host, host_to_dev};
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Frame position per line
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prev_r <= 2'h3;
			busy_r <= 2'h0;
			cnt_r <= '{0, 0};
		end
		else
		begin
			prev_r <= ln;
			for (int i = 0; i < 2; i++)
			begin
				cnt_r[i] <= busy_r[i] ? cnt_r[i] + 1 : 0;
				if (!busy_r[i])
					busy_r[i] <= prev_r[i] & ~ln[i];
				else if (cnt_r[i] == STOP_AT)
					busy_r[i] <= 1'b0;
			end
		end
	end
	AST_EXT_RESET: assert property (external_reset_in |-> ##[0:1] reset_status)
		else $error("reset status low during external reset");
	AST_RESET_HOLD: assert property ($fell(external_reset_in) |-> reset_status [*8])
		else $error("reset ended too early");
	AST_RESET_END: assert property ($fell(external_reset_in) |-> ##[RST_LO:RST_HI] !reset_status)
		else $error("reset status stuck high");
	AST_TX_QUIET: assert property (reset_status |-> dev_to_host)
		else $error("device line active in reset");
	AST_H2D_START: assert property (busy_r[0] && cnt_r[0] == START_AT |-> !host_to_dev)
		else $error("host start bit short");
	AST_D2H_START: assert property (busy_r[1] && cnt_r[1] == START_AT |-> !dev_to_host)
		else $error("device start bit short");
	AST_H2D_STOP: assert property (busy_r[0] && cnt_r[0] == STOP_AT |-> host_to_dev)
		else $error("host stop bit low");
	AST_D2H_STOP: assert property (busy_r[1] && cnt_r[1] == STOP_AT |-> dev_to_host)
		else $error("device stop bit low");
endmodule

// ==== bench/tb_top.sv ====
// ==========
// Bench top
module tb_top
	import serial_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] cmd; logic [7:0] dat; logic [7:0] rep; logic intr;} row_t;
	localparam row_t ROWS [3] = '{'{8'h12, 8'h34, 8'h78, 1'b0}, '{8'h28, 8'h57, 8'hA5, 1'b0},
		'{8'hAB, 8'hAB, 8'h14, 1'b1}};
	logic sys_clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, ack, irq, port_ready;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rdat, q;
	logic cmd_valid, in_valid, cmd_done = 0, out_valid = 0, out_ready, int_valid = 0, int_ready;
	logic [7:0] cmd_code, in_data, out_data = 0, int_code = 0;
	logic baud_set = 0, ferr;
	logic [2:0] baud_code = 0;
	logic [3:0] sel = 4'hF;
	logic [8:0] v;
	logic [8:0] rxq [$];
	int fail_count = 0, comparisons = 0, ferr_cnt = 0;
	serial_link_if link();
	command_port_host command_port_host_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .link(link));
	command_port_device #(.GAP_CYC(200), .RST_DELAY_CYC(20)) command_port_device_inst (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link), .port_ready_o(port_ready),
		.cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .in_valid_o(in_valid),
		.in_data_o(in_data), .cmd_done_i(cmd_done), .out_valid_i(out_valid),
		.out_data_i(out_data), .out_ready_o(out_ready), .int_valid_i(int_valid),
		.int_code_i(int_code), .int_ready_o(int_ready), .baud_set_i(baud_set),
		.baud_code_i(baud_code), .frame_err_o(ferr));
	serial_link_props #(.RST_DELAY_CYC(20), .BIT(10)) serial_link_props_inst (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .host_to_dev(link.host_to_dev),
		.dev_to_host(link.dev_to_host), .external_reset_in(link.external_reset_in),
		.reset_status(link.reset_status));
	always #50 sys_clk_i = ~sys_clk_i;
	always @(negedge sys_clk_i)
	begin
		if (cmd_valid === 1'b1)
			rxq.push_back({1'b1, cmd_code});
		else if (in_valid === 1'b1)
			rxq.push_back({1'b0, in_data});
	end
	always @(negedge sys_clk_i)
		if (ferr === 1'b1)
			ferr_cnt++;
	// ==========
	// Tasks
	task final_report;
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task tmo;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
		fail_count++;
		final_report;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge sys_clk_i);
			n++;
			if (n > 5000)
				tmo;
		end
		while (ack !== 1'b1);
		r = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1, a, d, r);
	endtask
	task poll(input logic [7:0] a, input int b, input logic val);
		int n;
		n = 0;
		do
		begin
			wb(0, a, 0, q);
			n++;
		end
		while (n < 3000 && q[b] !== val);
		if (q[b] !== val)
			tmo;
	endtask
	task wait_rx;
		int n;
		for (n = 0; n < 5000 && rxq.size() == 0; n++)
			@(negedge sys_clk_i);
		if (rxq.size() == 0)
			tmo;
		v = rxq.pop_front();
	endtask
	task dev_out(input logic i, input logic [7:0] b);
		int n;
		@(posedge sys_clk_i);
		int_valid <= i;
		int_code <= b;
		out_valid <= !i;
		out_data <= b;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
			if (n > 5000)
				tmo;
		end
		while ((i ? int_ready : out_ready) !== 1'b1);
		int_valid <= 0;
		out_valid <= 0;
	endtask
	task done_pulse;
		@(posedge sys_clk_i);
		cmd_done <= 1;
		@(posedge sys_clk_i);
		cmd_done <= 0;
	endtask
	task dev_baud(input logic [2:0] c);
		@(posedge sys_clk_i);
		baud_set <= 1;
		baud_code <= c;
		@(posedge sys_clk_i);
		baud_set <= 0;
	endtask
	task dev_reset;
		wr(REG_CFG, 32'h2A);
		wb(0, REG_STATUS, 0, q);
		chk(32'(q[ST_RESET]), 32'h1);
		chk(32'(port_ready), 32'h0);
		wr(REG_CFG, 32'h22);
		poll(REG_STATUS, ST_RESET, 1'b0);
		chk(32'(port_ready), 32'h1);
		rxq.delete();
	endtask
	// ==========
	// Sequence
	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1;
		wb(0, REG_CFG, 0, q);
		chk(q, 32'h77);
		wb(0, REG_MASK, 0, q);
		chk(q, 32'h0);
		wb(0, 8'hFC, 0, q);
		chk(q, 32'h0);
		dev_reset;
		wr(REG_MASK, 32'h1);
		foreach (ROWS[k])
		begin
			wr(REG_CMD, 32'(ROWS[k].cmd));
			wait_rx;
			chk(32'(v), 32'({1'b1, ROWS[k].cmd}));
			wr(REG_TXDATA, 32'(ROWS[k].dat));
			wait_rx;
			chk(32'(v), 32'({1'b0, ROWS[k].dat}));
			dev_out(ROWS[k].intr, ROWS[k].rep);
			poll(REG_STATUS, ST_RX, 1'b1);
			chk(32'(irq), 32'h1);
			wb(0, REG_RXDATA, 0, q);
			chk(32'(q[7:0]), 32'(ROWS[k].rep));
			wr(REG_STATUS, 32'h1);
			chk(32'(irq), 32'h0);
			done_pulse;
		end
		// Reset in mid-command, then a fresh packet
		wr(REG_CMD, 32'h33);
		wait_rx;
		dev_reset;
		wr(REG_CMD, 32'h44);
		wait_rx;
		chk(32'(v), 32'h144);
		wb(0, REG_STATUS, 0, q);
		chk(32'(q[ST_FERR]), 32'h0);
		// Stale, malformed and wrong-rate packets
		done_pulse;
		wr(REG_STATUS, 32'h7);
		wr(REG_TXDATA, 32'h57);
		repeat (500) @(posedge sys_clk_i);
		wr(REG_TXDATA, 32'hAB);
		wr(REG_TXDATA, 32'h66);
		repeat (400) @(posedge sys_clk_i);
		chk(32'(rxq.size()), 32'h0);
		wb(0, REG_STATUS, 0, q);
		chk(32'(q[ST_TXDONE]), 32'h1);
		wr(REG_TXDATA, 32'h57);
		wr(REG_TXDATA, 32'h12);
		wr(REG_TXDATA, 32'hAB);
		wr(REG_TXDATA, 32'h66);
		repeat (400) @(posedge sys_clk_i);
		chk(32'(rxq.size()), 32'h0);
		// Device at 2 Mbit/s sees a 1 Mbit/s zero byte with a low stop bit
		dev_baud(3'h1);
		wr(REG_TXDATA, 32'h00);
		repeat (300) @(posedge sys_clk_i);
		chk(32'(ferr_cnt), 32'h1);
		dev_baud(3'h2);
		wr(REG_CMD, 32'h45);
		wait_rx;
		chk(32'(v), 32'h145);
		// Host at 2 Mbit/s sees the same fault
		wr(REG_CFG, 32'h12);
		dev_out(0, 8'h00);
		poll(REG_STATUS, ST_FERR, 1'b1);
		chk(32'(q[ST_RX]), 32'h0);
		wr(REG_CFG, 32'h22);
		// Write without lane 0 has no effect
		sel <= 4'hE;
		wr(REG_MASK, 32'h7);
		sel <= 4'hF;
		wb(0, REG_MASK, 0, q);
		chk(q, 32'h1);
		final_report;
	end
endmodule
